//--- verilog/tlc_pkg.sv
// package for the transponder link crc-8 block: polynomial, preset, widths, carriers
// assumes a single clk_sys domain and synchronous active-low reset
package tlc_pkg;
    localparam int TLC_CRC_W = 8; // code width
    localparam logic [7:0] TLC_POLY = 8'h1d; // u^8+u^4+u^3+u^2+1
    localparam logic [7:0] TLC_PRESET = 8'hff; // preset at stream start
    localparam int TLC_DATA_W = 8; // bits per input beat
    localparam int TLC_FIFO_DEPTH = 4; // words in the output fifo
    localparam logic [7:0] TLC_FIFO_RST = 8'h00; // fifo data reset value
    // one beat of the outgoing stream
    typedef struct packed {
        logic [7:0] data; // stream byte, after optional encryption
        logic is_crc; // this byte is the appended code
        logic last; // final byte of the stream
    } tlc_beat_s;
    localparam int TLC_BEAT_W = $bits(tlc_beat_s);
    // kind of stream being protected
    typedef enum logic [0:0] {
        TLC_KIND_CMD = 1'b0,
        TLC_KIND_DATA = 1'b1
    } tlc_kind_e;
endpackage

//--- verilog/tlc_fifo.sv
// small synchronous fifo with valid/ready on both sides
// assumes clk_sys domain; width and depth are parameters, depth a power of two
`timescale 1ns/1ns
module tlc_fifo
    import tlc_pkg::*;
#(
    parameter int WIDTH = TLC_BEAT_W,
    parameter int DEPTH = TLC_FIFO_DEPTH
)
(
    input wire logic clk_sys,
    input wire logic rst_n,
    input wire logic [WIDTH-1:0] in_data,
    input wire logic in_valid,
    output logic in_ready,
    output logic [WIDTH-1:0] out_data,
    output logic out_valid,
    input wire logic out_ready
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem_r [DEPTH]; // storage array
    logic [AW-1:0] wr_ptr_r; // write index
    logic [AW-1:0] rd_ptr_r; // read index
    logic [AW:0] count_r; // words held
    logic push; // write accepted
    logic pop; // read accepted

    // honest flags from the occupancy count
    assign in_ready = (count_r != (AW+1)'(DEPTH));
    assign out_valid = (count_r != '0);
    assign push = in_valid && in_ready;
    assign pop = out_valid && out_ready;
    assign out_data = mem_r[rd_ptr_r];

    // storage write
    always_ff @(posedge clk_sys)
    begin
        if (!rst_n)
        begin
            for (int i = 0; i < DEPTH; i++)
                mem_r[i] <= '0;
        end
        else if (push)
            mem_r[wr_ptr_r] <= in_data;
    end

    // pointers and count
    always_ff @(posedge clk_sys)
    begin
        if (!rst_n)
        begin
            wr_ptr_r <= '0;
            rd_ptr_r <= '0;
            count_r <= '0;
        end
        else
        begin
            if (push)
                wr_ptr_r <= wr_ptr_r + 1'b1;
            if (pop)
                rd_ptr_r <= rd_ptr_r + 1'b1;
            if (push && !pop)
                count_r <= count_r + 1'b1;
            else if (pop && !push)
                count_r <= count_r - 1'b1;
        end
    end
endmodule

//--- verilog/tlc_crc8_gen.sv
// reader-side crc-8 generator for the transponder downlink stream
// assumes bytes from same-clock logic, a keystream byte from an external cipher, and a
// downstream serialiser draining the output fifo
`timescale 1ns/1ns
// Summary of operation
// - every outgoing command and data stream gets crc
// - polynomial 0x1d on both sides
// - register preset to 0xff each stream
// - code covers command/address or plain data bits
// - crypto mode encrypts the code as well
module tlc_crc8_gen
    import tlc_pkg::*;
#(
    parameter int FIFO_DEPTH = TLC_FIFO_DEPTH
)
(
    input wire logic clk_sys,
    input wire logic rst_n,
    input wire logic crypto_en,
    input wire logic [7:0] key_byte,
    output logic key_take,
    input wire logic [7:0] in_data,
    input wire logic in_kind,
    input wire logic in_last,
    input wire logic in_valid,
    output logic in_ready,
    output logic [7:0] out_data,
    output logic out_is_crc,
    output logic out_last,
    output logic out_valid,
    input wire logic out_ready,
    output logic busy,
    output logic [7:0] crc_value,
    output logic kind_cmd
);
    // stream states, gray order idle -> body -> code
    // idle: no stream open, remainder holds the preset
    // body: at least one byte taken, more may follow
    // code: last byte taken, the remainder waits for fifo room
    // only one bit flips on idle -> body and body -> code; code -> idle flips both bits
    // the unused code 2'b10 falls back to idle
    typedef enum logic [1:0] {
        TLC_ST_IDLE = 2'b00,
        TLC_ST_BODY = 2'b01,
        TLC_ST_CODE = 2'b11
    } tlc_state_e;

    tlc_state_e state_r; // stream state
    tlc_state_e state_nxt; // next stream state
    logic [7:0] crc_r; // running remainder
    logic [7:0] crc_upd; // remainder after current byte
    logic kind_r; // kind of current stream
    tlc_beat_s beat; // beat into the fifo
    logic beat_valid; // beat offered to fifo
    logic fifo_ready; // fifo can accept
    logic [TLC_BEAT_W-1:0] fifo_out; // raw fifo output
    tlc_beat_s fifo_beat; // typed fifo output
    logic take_body; // body byte accepted
    logic take_code; // code byte accepted

    // shift one byte msb first through the 0x1d divider, no final inversion
    // bit 7 of the byte meets the divider first
    // the feedback bit is the top remainder bit xor the data bit
    // the loop unrolls into a plain xor tree of depth eight
    // no reflection and no output xor, so the far side
    // can run the same divider over body and code alike
    function automatic logic [7:0] crc8_byte(input logic [7:0] crc, input logic [7:0] d);
        logic [7:0] c;
        c = crc;
        for (int i = 7; i >= 0; i--)
        begin
            if (c[7] ^ d[i])
                c = {c[6:0], 1'b0} ^ TLC_POLY;
            else
                c = {c[6:0], 1'b0};
        end
        return c;
    endfunction

    // plain byte feeds the code, so the code covers unencrypted bits
    // in idle the preset is used directly, so a stream that
    // starts right after the code beat never sees a stale remainder
    // command and data streams share the same coverage
    assign crc_upd = crc8_byte((state_r == TLC_ST_IDLE) ? TLC_PRESET : crc_r, in_data);

    // body bytes pass through while the fifo has room
    // input is closed for the one beat that carries the code
    // a full fifo stalls the source, nothing is dropped
    assign in_ready = (state_r != TLC_ST_CODE) && fifo_ready;
    assign take_body = in_valid && in_ready;
    assign take_code = (state_r == TLC_ST_CODE) && fifo_ready;

    // beat builder, keystream xor applies to body and code alike
    // the code beat takes priority over any waiting body byte
    // key_byte must be valid whenever crypto_en is high
    // one keystream byte is used per beat pushed
    // in plain mode the keystream is neither used nor advanced
    always_comb
    begin
        beat = '0;
        beat_valid = 1'b0;
        if (state_r == TLC_ST_CODE)
        begin
            beat.data = crc_r ^ (crypto_en ? key_byte : 8'h00);
            beat.is_crc = 1'b1;
            beat.last = 1'b1;
            beat_valid = 1'b1;
        end
        else
        begin
            beat.data = in_data ^ (crypto_en ? key_byte : 8'h00);
            beat.last = 1'b0;
            beat_valid = in_valid;
        end
    end
    // cipher step follows the push, so key order matches beat order
    assign key_take = crypto_en && beat_valid && fifo_ready;

    // next state
    // a single-byte stream goes straight from idle to code
    // the code beat leaves only when the fifo takes it
    always_comb
    begin
        state_nxt = state_r;
        unique case (state_r)
            TLC_ST_IDLE, TLC_ST_BODY:
            begin
                if (take_body && in_last)
                    state_nxt = TLC_ST_CODE; // code follows last byte
                else if (take_body)
                    state_nxt = TLC_ST_BODY;
            end
            TLC_ST_CODE:
            begin
                if (take_code)
                    state_nxt = TLC_ST_IDLE;
            end
            default: state_nxt = TLC_ST_IDLE;
        endcase
    end

    // state register
    always_ff @(posedge clk_sys)
    begin
        if (!rst_n)
            state_r <= TLC_ST_IDLE;
        else
            state_r <= state_nxt;
    end

    // remainder: preset after reset and after each stream, updated per byte
    // the preset is written as the code beat leaves, so the
    // next stream starts from all ones without an extra cycle
    always_ff @(posedge clk_sys)
    begin
        if (!rst_n)
            crc_r <= TLC_PRESET;
        else if (take_body)
            crc_r <= crc_upd;
        else if (take_code)
            crc_r <= TLC_PRESET;
    end

    // stream kind latched on first byte
    // later changes of in_kind inside a stream are ignored
    always_ff @(posedge clk_sys)
    begin
        if (!rst_n)
            kind_r <= TLC_KIND_CMD;
        else if (take_body && state_r == TLC_ST_IDLE)
            kind_r <= in_kind;
    end

    // output buffer between the coder and the serialiser
    // holds body and code beats, data stable while not taken
    tlc_fifo #(
        .WIDTH(TLC_BEAT_W),
        .DEPTH(FIFO_DEPTH)
    ) u_fifo (
        .clk_sys(clk_sys),
        .rst_n(rst_n),
        .in_data(beat),
        .in_valid(beat_valid),
        .in_ready(fifo_ready),
        .out_data(fifo_out),
        .out_valid(out_valid),
        .out_ready(out_ready)
    );

    // fifo output split into fields
    // out_last is set only on the code beat
    // busy and crc_value come straight from registers
    assign fifo_beat = tlc_beat_s'(fifo_out);
    assign out_data = fifo_beat.data;
    assign out_is_crc = fifo_beat.is_crc;
    assign out_last = fifo_beat.last;
    assign busy = (state_r != TLC_ST_IDLE);
    assign crc_value = crc_r;
    assign kind_cmd = (kind_r == TLC_KIND_CMD);
endmodule

//--- test/tlc_tb_pkg.sv
// bench-side helper: reference crc-8 byte step
// assumes msb-first shifting and no final inversion
package tlc_tb_pkg;
    // one byte into the remainder, polynomial 1d
    function automatic logic [7:0] tlc_tb_step(input logic [7:0] c, input logic [7:0] d);
        logic [7:0] r;
        r = c ^ d;
        for (int i = 0; i < 8; i++)
            r = r[7] ? ({r[6:0], 1'b0} ^ 8'h1d) : {r[6:0], 1'b0};
        return r;
    endfunction
endpackage

//--- test/tlc_gen_properties.sv
// port-level assertions for the crc-8 generator
// assumes binding to tlc_crc8_gen, single clk_sys domain
`timescale 1ns/1ns
module tlc_gen_properties
    import tlc_pkg::*;
    import tlc_tb_pkg::*;
#(
    parameter int FIFO_DEPTH = 4
)
(
    input wire logic clk_sys,
    input wire logic rst_n,
    input wire logic crypto_en,
    input wire logic key_take,
    input wire logic [7:0] in_data,
    input wire logic in_kind,
    input wire logic in_last,
    input wire logic in_valid,
    input wire logic in_ready,
    input wire logic [7:0] out_data,
    input wire logic out_is_crc,
    input wire logic out_last,
    input wire logic out_valid,
    input wire logic out_ready,
    input wire logic busy,
    input wire logic [7:0] crc_value
);
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rst_n);
    logic take; // byte accepted this cycle
    assign take = in_valid && in_ready;
    idle_preset_a: assert property (!busy |-> crc_value == TLC_PRESET) else $error("idle remainder not preset");
    crc_step_a: assert property (take && !in_last |=> crc_value == tlc_tb_step($past(crc_value), $past(in_data)))
        else $error("remainder step wrong");
    code_pending_a: assert property (take && in_last |=> !in_ready) else $error("input open during code");
    code_flags_a: assert property (out_valid && out_is_crc |-> out_last) else $error("code not last");
    out_hold_a: assert property (out_valid && !out_ready |=> out_valid && $stable(out_data))
        else $error("output byte changed");
    key_gate_a: assert property (key_take |-> crypto_en) else $error("key used in plain mode");
    key_beat_a: assert property (take && crypto_en |-> key_take) else $error("body beat not keyed");
    stream_end_a: assert property (take && in_last |-> ##[1:8] !busy) else $error("stream never closed");
    cover property (take && in_last && crypto_en);
    cover property (out_valid && !out_ready && !in_ready);
    cover property (take && !busy && in_kind);
endmodule

//--- test/tlc_tag_model.sv
// transponder model: drains the stream, decrypts, checks the code
// assumes the same keystream start and step as the bench cipher
`timescale 1ns/1ns
module tlc_tag_model
    import tlc_tb_pkg::*;
(
    input wire logic clk_sys,
    input wire logic rst_n,
    input wire logic crypto_en,
    input wire logic slow,
    input wire logic [7:0] out_data,
    input wire logic out_is_crc,
    input wire logic out_last,
    input wire logic out_valid,
    output logic out_ready,
    output int ok_cnt,
    output int bad_cnt
);
    logic [7:0] crc_r; // running check remainder
    logic [7:0] k_r; // mirrored keystream
    logic [7:0] d; // deciphered byte
    assign d = out_data ^ (crypto_en ? k_r : 8'h00);
    // take bytes, stalling every other cycle when slow
    always @(posedge clk_sys)
    begin
        if (!rst_n)
        begin
            crc_r <= 8'hff;
            k_r <= 8'h3c;
            ok_cnt <= 0;
            bad_cnt <= 0;
            out_ready <= 1'b0;
        end
        else
        begin
            out_ready <= slow ? ~out_ready : 1'b1;
            if (out_valid && out_ready)
            begin
                if (crypto_en)
                    k_r <= k_r + 8'h07;
                if (out_is_crc != out_last)
                    bad_cnt <= bad_cnt + 1;
                if (!out_is_crc)
                    crc_r <= tlc_tb_step(crc_r, d);
                else
                begin
                    crc_r <= 8'hff;
                    // count ok only on a good code, any other code counts as bad
                    if (d === crc_r)
                        ok_cnt <= ok_cnt + 1;
                    else
                        bad_cnt <= bad_cnt + 1;
                end
            end
        end
    end
endmodule

//--- test/test_transponder_link_crc8.sv
// self-checking bench for the crc-8 generator
// assumes the tag model as drain and a counting keystream
`timescale 1ns/1ns
module test_transponder_link_crc8;
    import tlc_pkg::*;
    logic clk_sys = 1'b0;
    logic rst_n = 1'b0;
    logic crypto_en = 1'b0;
    logic [7:0] key_byte = 8'h3c; // bench keystream
    logic [7:0] in_data = 8'h00;
    logic in_kind = 1'b0;
    logic in_last = 1'b0;
    logic in_valid = 1'b0;
    logic slow = 1'b0; // drain stalls when high
    logic key_take, in_ready, out_is_crc, out_last, out_valid, out_ready, busy, kind_cmd;
    logic [7:0] out_data, crc_value;
    int ok_cnt, bad_cnt;
    int n_fail = 0;
    int cmp_count = 0;
    `define CHK(a, b) begin cmp_count++; if ((a) !== (b)) begin n_fail++; \
        $display("Error t=%0t got=%h exp=%h", $time, a, b); end end
    always #20 clk_sys = ~clk_sys;
    // keystream advances on key_take, once per beat pushed in crypto mode
    always @(posedge clk_sys)
        key_byte <= !rst_n ? 8'h3c : (key_take ? key_byte + 8'h07 : key_byte);
    tlc_crc8_gen #(.FIFO_DEPTH(4)) tlc_crc8_gen_inst (.*);
    tlc_tag_model tlc_tag_model_inst (.*);
    task automatic end_sim();
        if (n_fail == 0 && cmp_count > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask
    // offer one byte and hold it until taken
    task automatic put(input logic [7:0] d, input logic l);
        int n;
        in_data <= d;
        in_last <= l;
        in_valid <= 1'b1;
        n = 0;
        do
        begin
            @(posedge clk_sys);
            n++;
        end while (in_ready !== 1'b1 && n < 50);
        if (n >= 50)
        begin
            n_fail++;
            end_sim();
        end
    endtask
    // send a stream and wait for the tag verdict
    task automatic stream(input logic [7:0] b[$], input logic k, input logic cy);
        int n;
        int base;
        base = ok_cnt + bad_cnt;
        crypto_en <= cy;
        in_kind <= k;
        foreach (b[i]) put(b[i], i == b.size() - 1);
        in_valid <= 1'b0;
        n = 0;
        while (ok_cnt + bad_cnt == base && n < 200)
        begin
            @(posedge clk_sys);
            n++;
        end
        if (n >= 200)
        begin
            n_fail++;
            end_sim();
        end
        @(posedge clk_sys);
        `CHK(ok_cnt + bad_cnt, base + 1)
        `CHK(bad_cnt, 0)
        `CHK(kind_cmd, k == TLC_KIND_CMD)
        `CHK(crc_value, TLC_PRESET)
    endtask
    task automatic sc_single();
        stream('{8'ha1}, TLC_KIND_CMD, 1'b0);
    endtask
    task automatic sc_slow_data();
        slow <= 1'b1;
        stream('{8'h00, 8'hff, 8'h80, 8'h01, 8'h5a, 8'hc3}, TLC_KIND_DATA, 1'b0);
        slow <= 1'b0;
    endtask
    task automatic sc_crypto();
        stream('{8'h12, 8'h34, 8'h56}, TLC_KIND_CMD, 1'b1);
        slow <= 1'b1;
        stream('{8'hde, 8'had, 8'hbe, 8'hef, 8'h00}, TLC_KIND_DATA, 1'b1);
        slow <= 1'b0;
    endtask
    initial
    begin
        repeat (12) @(posedge clk_sys);
        rst_n <= 1'b1;
        sc_single();
        sc_slow_data();
        sc_crypto();
        end_sim();
    end
endmodule
bind tlc_crc8_gen tlc_gen_properties #(.FIFO_DEPTH(FIFO_DEPTH)) tlc_gen_properties_inst (.*);
